// ===== dv/enbom_line_model.sv
// remote e1 terminal model: drives the received overhead strobes of one channel
// assumes its tasks are entered just after a rising pclk edge
module enbom_line_model (
  input wire logic pclk,
  output enbom_pkg::enbom_line_type line_out
);
  import enbom_pkg::*;
  logic [1:0] gap = 2'b00;

  // in sync from time zero, nothing strobed
  initial begin
    line_out = '0;
    line_out.crc_mf_sync = 1'b1;
    line_out.basic_sync = 1'b1;
  end

  // one nfas frame; idle gaps of 0..3 cycles mimic a slow far end
  task automatic nfas(input logic [4:0] sa, input logic a);
    gap = gap + 2'd1;
    repeat (gap) @(posedge pclk);
    line_out.nfas_strobe <= 1'b1;
    line_out.sa <= sa;
    line_out.a_bit <= a;
    @(posedge pclk);
    // data off the strobe shows the inverse, never the last value
    line_out.nfas_strobe <= 1'b0;
    line_out.sa <= ~sa;
    line_out.a_bit <= ~a;
    @(posedge pclk);
  endtask

  // four frames, first received bit is codeword bit 3
  task automatic smf(input logic [3:0] c6, input logic [3:0] c7, input logic [3:0] c8, input logic [7:0] r);
    for (int k = 3; k >= 0; k--) begin
      nfas({r[k], r[k + 4], c6[k], c7[k], c8[k]}, 1'b0);
    end
    line_out.smf_end <= 1'b1;
    @(posedge pclk);
    line_out.smf_end <= 1'b0;
    @(posedge pclk);
  endtask

  // e bits as pulses every other cycle
  task automatic e_run(input int n, input logic b);
    repeat (n) begin
      line_out.e_strobe <= 1'b1;
      line_out.e_bit <= b;
      @(posedge pclk);
      line_out.e_strobe <= 1'b0;
      line_out.e_bit <= ~b;
      @(posedge pclk);
    end
  endtask

  task automatic sync(input logic c);
    line_out.crc_mf_sync <= c;
    @(posedge pclk);
  endtask
endmodule

// ===== dv/enbom_monitor_asserts.sv
// checker bound to the overhead monitor top: apb, line strobes and irq
// assumes enables change only through apb writes of whole aligned words
module enbom_monitor_asserts #(
  parameter logic [23:0] RAI_CYCLES = 24'd100000,
  parameter logic [23:0] SEC_CYCLES = 24'd10000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire enbom_pkg::enbom_line_type line_in,
  input wire logic irq
);
  import enbom_pkg::*;
  logic wr_acc;
  logic [7:0] cw_ctrl;
  logic [5:0] oh_en;
  logic [11:0] hist;
  logic [11:0] next_hist;
  logic [2:0] sa7_win;
  logic link_v;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow enables, written at the same access edge as the design
  assign wr_acc = psel && penable && pwrite && paddr[1:0] == 2'b00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw_ctrl <= 8'h00;
      oh_en <= 6'h00;
    end else if (wr_acc && paddr[11:2] == 10'h05c) begin
      cw_ctrl <= pwdata[7:0];
    end else if (wr_acc && paddr[11:2] == 10'h060) begin
      oh_en <= pwdata[5:0];
    end
  end

  // sa6 history and sa7 window advance on in-sync frames only
  assign next_hist = (line_in.nfas_strobe && line_in.basic_sync) ? {hist[10:0], line_in.sa[2]} : hist;
  assign link_v = $countones(~sa7_win) >= 2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist <= 12'h000;
      sa7_win <= 3'b111;
    end else if (line_in.nfas_strobe && line_in.basic_sync) begin
      hist <= next_hist;
      sa7_win <= {sa7_win[1:0], line_in.sa[1]};
    end
  end

  chk_slverr_unaligned: assert property (
    psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0) else $error("misaligned access accepted");
  chk_nt_crc_irq: assert property (
    line_in.smf_end && line_in.crc_mf_sync && next_hist[3:0] inside {4'h2, 4'h3} && oh_en[5] |=> irq)
    else $error("nt crc codeword gave no irq");
  chk_nt_febe_irq: assert property (
    line_in.smf_end && line_in.crc_mf_sync && next_hist[3:0] inside {4'h1, 4'h3} && oh_en[4] |=> irq)
    else $error("nt febe codeword gave no irq");
  chk_febe_irq: assert property (
    line_in.e_strobe && !line_in.e_bit && line_in.crc_mf_sync && oh_en[3] |=> irq) else $error("e zero gave no irq");
  chk_irq_masked: assert property (
    cw_ctrl[5:0] == 6'h00 && oh_en == 6'h00 |-> !irq) else $error("irq with every enable off");
  chk_irq_sticky: assert property (
    irq && !(psel && penable && pwrite) |=> irq) else $error("irq dropped without a write");
  chk_pattern_irq: assert property (
    line_in.nfas_strobe && line_in.basic_sync && line_in.crc_mf_sync && !cw_ctrl[7] && cw_ctrl[5]
    && next_hist inside {12'h888, 12'haaa, 12'hccc, 12'heee, 12'hfff} |=> irq) else $error("sa6 pattern gave no irq");
  chk_link_irq: assert property (
    $changed(link_v) && oh_en[0] |-> ##[0:3] irq) else $error("link id toggle gave no irq");
endmodule

bind enbom_monitor enbom_monitor_asserts #(.RAI_CYCLES(RAI_CYCLES), .SEC_CYCLES(SEC_CYCLES)) enbom_monitor_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in), .irq(irq));

// ===== dv/tb.sv
// self-checking bench of the overhead monitor: apb master, line model, random codewords
// assumes short detector windows so the continuous statuses settle in a short run
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import enbom_pkg::*;
  localparam int RAI = 20;
  localparam int SEC = 2000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  enbom_line_type line_w;
  logic [31:0] seed = 32'd99;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [3:0] p7 = 4'h0;
  logic [3:0] p8 = 4'h0;
  logic [3:0] c7;
  logic [3:0] nib [5] = '{4'h8, 4'ha, 4'hc, 4'he, 4'hf};
  logic [9:0] regs [11] = '{10'h056, 10'h057, 10'h058, 10'h059, 10'h05a, 10'h05b, 10'h05c, 10'h05d, 10'h05f,
    10'h060, 10'h061};
  int n_errors = 0;
  int n_checks = 0;

  enbom_monitor #(.RAI_CYCLES(24'(RAI)), .SEC_CYCLES(24'(SEC))) enbom_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_w), .irq(irq));
  enbom_line_model enbom_line_model_inst (.pclk(pclk), .line_out(line_w));

  always #50 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // nt crc flag at bit 5, nt febe flag at bit 4
  function automatic logic [7:0] nt_exp(input logic [3:0] c);
    return {2'b00, c == 4'h2 || c == 4'h3, c == 4'h1 || c == 4'h3, 4'h0};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, {idx, 2'b00}, 8'h00);
    chk($sformatf("reg %h", idx), {24'h0, e}, rdata & {24'hffffff, m});
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, about two and a half times the expected run
  initial begin
    #4000000;
    n_errors++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[k]) rd(regs[k], 8'hff, 8'h00);
    apb(1'b0, 12'h178, 8'h00);
    chk("slverr", 32'h1, {31'h0, pslverr});
    apb(1'b0, 12'h171, 8'h00);
    chk("slverr", 32'h1, {31'h0, pslverr});
    wr(10'h059, 8'hff);
    rd(10'h059, 8'hff, 8'h00);
    v = xs();
    wr(10'h05c, v[7:0]);
    rd(10'h05c, 8'hff, v[7:0]);
    wr(10'h060, v[7:0]);
    rd(10'h060, 8'hff, {2'b00, v[5:0]});
    // plain codeword refresh, sa7 change irq on; one repeat of the old value
    wr(10'h060, 8'h00);
    wr(10'h05c, 8'h02);
    for (int k = 0; k < 5; k++) begin
      v = xs();
      c7 = (k == 2) ? p7 : v[3:0];
      enbom_line_model_inst.smf(v[11:8], c7, v[7:4], v[19:12]);
      rd(10'h059, 8'hff, {4'h0, c7});
      rd(10'h05a, 8'hff, {4'h0, v[7:4]});
      rd(10'h058, 8'hff, {4'h0, v[11:8]});
      rd(10'h056, 8'hff, {4'h0, v[15:12]});
      rd(10'h05d, 8'h03, {6'h0, c7 != p7, v[7:4] != p8});
      chk("irq", {31'h0, c7 != p7}, {31'h0, irq});
      wr(10'h05d, 8'h3f);
      rd(10'h05d, 8'h03, 8'h00);
      p7 = c7;
      p8 = v[7:4];
    end
    // de-bounce: first new value held, second taken
    wr(10'h05c, 8'h40);
    for (int k = 0; k < 2; k++) begin
      v = xs();
      enbom_line_model_inst.smf(4'h0, ~p7, ~p8, v[7:0]);
      rd(10'h059, 8'hff, {4'h0, k ? ~p7 : p7});
      rd(10'h05a, 8'hff, {4'h0, k ? ~p8 : p8});
    end
    enbom_line_model_inst.sync(1'b0);
    repeat (2) enbom_line_model_inst.smf(4'h0, p7, p8, v[7:0]);
    rd(10'h059, 8'hff, {4'h0, ~p7});
    rd(10'h05a, 8'hff, {4'h0, ~p8});
    enbom_line_model_inst.sync(1'b1);
    // every nt codeword case
    wr(10'h05c, 8'h00);
    wr(10'h061, 8'h3f);
    wr(10'h060, 8'h30);
    for (int k = 0; k < 4; k++) begin
      v = xs();
      enbom_line_model_inst.smf(4'(k), v[3:0], v[7:4], v[15:8]);
      rd(10'h061, 8'h30, nt_exp(4'(k)));
      chk("irq", {31'h0, |nt_exp(4'(k))}, {31'h0, irq});
      wr(10'h061, 8'h30);
    end
    // five patterns in both alignment modes, event irq on for odd ones
    wr(10'h060, 8'h00);
    for (int al = 0; al < 2; al++) begin
      for (int i = 0; i < 5; i++) begin
        wr(10'h05c, {1'(al), 1'b0, 1'(i), 5'h00});
        wr(10'h05b, 8'h1f);
        wr(10'h05d, 8'h3f);
        repeat (3) begin
          v = xs();
          enbom_line_model_inst.smf(nib[i], v[3:0], v[7:4], v[15:8]);
        end
        rd(10'h05b, 8'h1 << i, 8'h1 << i);
        rd(10'h05d, 8'h20, 8'h20);
        chk("irq", {31'h0, 1'(i)}, {31'h0, irq});
      end
    end
    // continuous detectors: rai first, block errors after five windows
    wr(10'h05c, 8'h00);
    wr(10'h060, 8'h0f);
    wr(10'h061, 8'h3f);
    enbom_line_model_inst.nfas(5'h1f, 1'b1);
    enbom_line_model_inst.e_run(RAI, 1'b0);
    rd(10'h05f, 8'h06, 8'h04);
    rd(10'h061, 8'h04, 8'h04);
    enbom_line_model_inst.e_run(7 * SEC / 2, 1'b0);
    rd(10'h05f, 8'h06, 8'h06);
    enbom_line_model_inst.nfas(5'h1f, 1'b0);
    rd(10'h05f, 8'h04, 8'h00);
    // link id: sa7 bits 0,0,1,1 after a clean window
    repeat (3) enbom_line_model_inst.nfas(5'h1f, 1'b0);
    wr(10'h061, 8'h3f);
    for (int k = 0; k < 4; k++) begin
      enbom_line_model_inst.nfas({3'b111, k > 1, 1'b1}, 1'b0);
      rd(10'h05f, 8'h01, {7'h0, k == 1 || k == 2});
    end
    rd(10'h061, 8'h01, 8'h01);
    close_out();
  end
endmodule

// ===== logic/enbom_cfg.svh
// constants of the e1 national-bit overhead monitor: register indices, field positions, reset values, timing counts
// assumes a 10 MHz apb clock; register index n sits at byte address 4*n
`ifndef ENBOM_CFG_SVH
`define ENBOM_CFG_SVH

// register indices (byte address = 4 * index)
`define ENBOM_IDX_SA4 10'h056
`define ENBOM_IDX_SA5 10'h057
`define ENBOM_IDX_SA6 10'h058
`define ENBOM_IDX_SA7 10'h059
`define ENBOM_IDX_SA8 10'h05a
`define ENBOM_IDX_PAT 10'h05b
`define ENBOM_IDX_CW_CTRL 10'h05c
`define ENBOM_IDX_CW_FLAGS 10'h05d
`define ENBOM_IDX_OH_STATUS 10'h05f
`define ENBOM_IDX_OH_CTRL 10'h060
`define ENBOM_IDX_OH_FLAGS 10'h061

// reset values
`define ENBOM_RST_CW_CTRL 8'h00
`define ENBOM_RST_OH_CTRL 6'h00

// fields of the codeword control register
`define ENBOM_BIT_ALIGN_SEL 7
`define ENBOM_BIT_DEBOUNCE 6
`define ENBOM_BIT_SIXTH_IRQ 5
// codeword store index of each national bit (sa4 .. sa8 = 4 .. 0)
`define ENBOM_CW_SA6 2
`define ENBOM_CW_SA7 1

// fields of the overhead flag and enable registers
`define ENBOM_OH_NT_CRC 5
`define ENBOM_OH_NT_FEBE 4
`define ENBOM_OH_FEBE 3
`define ENBOM_OH_RAI 2
`define ENBOM_OH_CFEBE 1
`define ENBOM_OH_LINK 0

// sa6 twelve-bit patterns
`define ENBOM_PAT_888 12'h888
`define ENBOM_PAT_AAA 12'haaa
`define ENBOM_PAT_CCC 12'hccc
`define ENBOM_PAT_EEE 12'heee
`define ENBOM_PAT_FFF 12'hfff

// nt codewords
`define ENBOM_NT_CRC_A 4'h2
`define ENBOM_NT_CRC_B 4'h3
`define ENBOM_NT_FEBE_A 4'h1
`define ENBOM_NT_FEBE_B 4'h3

// timing
`define ENBOM_CLK_HZ 10000000
`define ENBOM_RAI_MS 10
`define ENBOM_RAI_CYCLES ((`ENBOM_CLK_HZ / 1000) * `ENBOM_RAI_MS)
`define ENBOM_SEC_S 1
`define ENBOM_SEC_CYCLES (`ENBOM_CLK_HZ * `ENBOM_SEC_S)
`define ENBOM_CFEBE_MIN 11'd990
`define ENBOM_CFEBE_SECS 5

`endif

// ===== logic/enbom_cw_store.sv
// one national-bit codeword store with optional two-sample de-bounce
// assumes sample is already gated by crc multiframe synchronisation
module enbom_cw_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample,
  input wire logic debounce_en,
  input wire enbom_pkg::enbom_cw_type word,
  output enbom_pkg::enbom_cw_type stored,
  output logic changed
);
  import enbom_pkg::*;

  enbom_cw_type last_word;
  logic take;

  // with de-bounce a value must repeat over two sub-multiframes
  assign take = sample & (~debounce_en | (word == last_word));

  // previous received codeword, kept for the repeat check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word <= 4'h0;
    end else if (sample) begin
      last_word <= word;
    end
  end

  // stored value and one-cycle change pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored <= 4'h0;
      changed <= 1'b0;
    end else begin
      changed <= take & (word != stored);
      if (take) begin
        stored <= word;
      end
    end
  end
endmodule

// ===== logic/enbom_monitor.sv
// receive-side e1 national-bit overhead monitor with an apb register slave
// assumes framer strobes synchronous to pclk and an apb master on the same clock
// Functional notes
// - with de-bounce on, sa7 store updates after two equal sub-multiframe codewords.
// - with de-bounce on, sa8 store updates after two equal sub-multiframe codewords.
// - with de-bounce off, stores refresh each sub-multiframe; enable resets to 0.
// - stored codewords hold while crc multiframe sync is lost.
// - align 0 compares any 12 sa6 bits; 1 compares three codewords; needs sync.
// - five pattern bits set on 0x888, 0xaaa, 0xccc, 0xeee, 0xfff.
// - summary sa6 event flag sets on any of the five patterns.
// - sa6 event flag drives interrupt only while its enable is 1.
// - each of sa4..sa8 stores sets its change flag when its value changes.
// - each change flag has its own interrupt enable.
// - rai status set when a=1 and e bit zero persist for 10 ms.
// - continuous febe status when e zeros reach 990 per second for 5 seconds.
// - link id status when at least 2 of last 3 sa7 bits are 0.
// - nt crc error flag interrupts only when its enable, reset 0, is set.
// - nt febe flag interrupts only when its enable, reset 0, is set.
// - nt crc error flag sets when sa6 codeword is 0010 or 0011.
// - nt febe flag sets when sa6 codeword is 0001 or 0011.
// - each continuous status sets a change flag on every toggle.
// - software clears a flag by writing 1 to its bit.
`include "enbom_cfg.svh"

module enbom_monitor #(
  parameter logic [23:0] RAI_CYCLES = 24'(`ENBOM_RAI_CYCLES),
  parameter logic [23:0] SEC_CYCLES = 24'(`ENBOM_SEC_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire enbom_pkg::enbom_line_type line_in,
  output logic irq
);
  import enbom_pkg::*;
  // bus decode
  logic [9:0] reg_idx;
  logic aligned;
  logic setup_phase;
  logic wr_access;
  logic mapped;
  logic [7:0] rd_value;
  // control registers
  logic [7:0] cw_ctrl;
  logic [5:0] oh_ctrl;
  // flags
  logic [4:0] pattern_flags;
  logic [5:0] cw_flags;
  logic [5:0] oh_flags;
  logic [4:0] pattern_clr;
  logic [5:0] cw_clr;
  logic [5:0] oh_clr;
  logic [4:0] pattern_set;
  logic [5:0] cw_set;
  logic [5:0] oh_set;
  // codeword assembly and stores
  enbom_cw_type cw_shift [0:4];
  enbom_cw_type next_cw [0:4];
  enbom_cw_type cw_stored [0:4];
  logic [4:0] cw_change;
  logic cw_sample;
  logic nfas_take;
  // sa6 pattern search
  logic [11:0] sa6_bits;
  logic [11:0] next_sa6_bits;
  logic [11:0] sa6_words;
  logic [11:0] next_sa6_words;
  logic [11:0] sa6_compare;
  logic compare_now;
  // continuous detectors
  logic a_latest;
  logic e_zero_latest;
  logic rai_cond;
  logic [23:0] rai_cnt;
  logic rai_status;
  logic [23:0] sec_cnt;
  logic sec_wrap;
  logic e_zero_event;
  logic [10:0] e_zero_cnt;
  logic [`ENBOM_CFEBE_SECS-1:0] cfebe_hist;
  logic cfebe_status;
  logic [2:0] sa7_window;
  logic link_status;
  logic [2:0] status_now;
  logic [2:0] status_prev;
  assign reg_idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup_phase = psel & ~penable;
  // zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  // address map check
  always_comb begin
    mapped = 1'b0;
    if (aligned) begin
      case (reg_idx)
        `ENBOM_IDX_SA4, `ENBOM_IDX_SA5, `ENBOM_IDX_SA6, `ENBOM_IDX_SA7, `ENBOM_IDX_SA8: mapped = 1'b1;
        `ENBOM_IDX_PAT, `ENBOM_IDX_CW_CTRL, `ENBOM_IDX_CW_FLAGS: mapped = 1'b1;
        `ENBOM_IDX_OH_STATUS, `ENBOM_IDX_OH_CTRL, `ENBOM_IDX_OH_FLAGS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // read multiplexer; reserved bits read as zero
  always_comb begin
    rd_value = 8'h00;
    case (reg_idx)
      `ENBOM_IDX_SA4: rd_value = {4'h0, cw_stored[4]};
      `ENBOM_IDX_SA5: rd_value = {4'h0, cw_stored[3]};
      `ENBOM_IDX_SA6: rd_value = {4'h0, cw_stored[2]};
      `ENBOM_IDX_SA7: rd_value = {4'h0, cw_stored[1]};
      `ENBOM_IDX_SA8: rd_value = {4'h0, cw_stored[0]};
      `ENBOM_IDX_PAT: rd_value = {3'h0, pattern_flags};
      `ENBOM_IDX_CW_CTRL: rd_value = cw_ctrl;
      `ENBOM_IDX_CW_FLAGS: rd_value = {2'h0, cw_flags};
      `ENBOM_IDX_OH_STATUS: rd_value = {5'h00, rai_status, cfebe_status, link_status};
      `ENBOM_IDX_OH_CTRL: rd_value = {2'h0, oh_ctrl};
      `ENBOM_IDX_OH_FLAGS: rd_value = {2'h0, oh_flags};
      default: rd_value = 8'h00;
    endcase
  end

  // read data and error captured in the setup cycle, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_value} : 32'h0000_0000;
      pslverr <= ~mapped;
    end
  end

  // control registers: full byte at the codeword control, six bits at the overhead control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw_ctrl <= `ENBOM_RST_CW_CTRL;
      oh_ctrl <= `ENBOM_RST_OH_CTRL;
    end else if (wr_access && aligned) begin
      if (reg_idx == `ENBOM_IDX_CW_CTRL) begin
        cw_ctrl <= pwdata[7:0];
      end
      if (reg_idx == `ENBOM_IDX_OH_CTRL) begin
        oh_ctrl <= pwdata[5:0];
      end
    end
  end

  // write-one-to-clear masks for the three flag registers
  always_comb begin
    pattern_clr = 5'h00;
    cw_clr = 6'h00;
    oh_clr = 6'h00;
    if (wr_access && aligned) begin
      if (reg_idx == `ENBOM_IDX_PAT) begin
        pattern_clr = pwdata[4:0];
      end
      if (reg_idx == `ENBOM_IDX_CW_FLAGS) begin
        cw_clr = pwdata[5:0];
      end
      if (reg_idx == `ENBOM_IDX_OH_FLAGS) begin
        oh_clr = pwdata[5:0];
      end
    end
  end

  // national bits only count while the basic frame is aligned
  assign nfas_take = line_in.nfas_strobe & line_in.basic_sync;
  // stores move only in crc multiframe sync, otherwise they hold
  assign cw_sample = line_in.smf_end & line_in.crc_mf_sync;

  // per national bit: assemble the codeword and keep it in a store
  generate
    for (genvar i = 0; i < 5; i++) begin : g_cw
      // next value lets a strobe and the sub-multiframe end share a cycle
      always_comb begin
        next_cw[i] = cw_shift[i];
        if (nfas_take) begin
          next_cw[i] = {cw_shift[i][2:0], line_in.sa[i]};
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cw_shift[i] <= 4'h0;
        end else begin
          cw_shift[i] <= next_cw[i];
        end
      end

      enbom_cw_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .sample(cw_sample),
        .debounce_en(cw_ctrl[`ENBOM_BIT_DEBOUNCE]),
        .word(next_cw[i]),
        .stored(cw_stored[i]),
        .changed(cw_change[i])
      );
    end
  endgenerate

  // sa6 bit stream and codeword stream, both as next values
  always_comb begin
    next_sa6_bits = sa6_bits;
    next_sa6_words = sa6_words;
    if (nfas_take) begin
      next_sa6_bits = {sa6_bits[10:0], line_in.sa[`ENBOM_CW_SA6]};
    end
    if (cw_sample) begin
      next_sa6_words = {sa6_words[7:0], next_cw[`ENBOM_CW_SA6]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa6_bits <= 12'h000;
      sa6_words <= 12'h000;
    end else begin
      sa6_bits <= next_sa6_bits;
      sa6_words <= next_sa6_words;
    end
  end

  // unaligned mode checks on every bit, aligned mode on every codeword boundary
  always_comb begin
    if (cw_ctrl[`ENBOM_BIT_ALIGN_SEL]) begin
      sa6_compare = next_sa6_words;
      compare_now = cw_sample;
    end else begin
      sa6_compare = next_sa6_bits;
      compare_now = nfas_take & line_in.crc_mf_sync;
    end
  end

  // pattern hits: bit 4 fff down to bit 0 888
  always_comb begin
    pattern_set = 5'h00;
    if (compare_now) begin
      pattern_set[4] = (sa6_compare == `ENBOM_PAT_FFF);
      pattern_set[3] = (sa6_compare == `ENBOM_PAT_EEE);
      pattern_set[2] = (sa6_compare == `ENBOM_PAT_CCC);
      pattern_set[1] = (sa6_compare == `ENBOM_PAT_AAA);
      pattern_set[0] = (sa6_compare == `ENBOM_PAT_888);
    end
  end

  // codeword flag sources: summary pattern event and the five change pulses
  assign cw_set = {|pattern_set, cw_change};

  // sticky flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_flags <= 5'h00;
      cw_flags <= 6'h00;
      oh_flags <= 6'h00;
    end else begin
      pattern_flags <= (pattern_flags & ~pattern_clr) | pattern_set;
      cw_flags <= (cw_flags & ~cw_clr) | cw_set;
      oh_flags <= (oh_flags & ~oh_clr) | oh_set;
    end
  end

  // latest a bit and latest e bit, feeding the rai detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_latest <= 1'b0;
      e_zero_latest <= 1'b0;
    end else begin
      if (nfas_take) begin
        a_latest <= line_in.a_bit;
      end
      if (line_in.e_strobe && line_in.crc_mf_sync) begin
        e_zero_latest <= ~line_in.e_bit;
      end
    end
  end

  // rai with e errors: the condition must stand unbroken for the whole interval
  assign rai_cond = line_in.crc_mf_sync & a_latest & e_zero_latest;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rai_cnt <= 24'h00_0000;
    end else if (!rai_cond) begin
      rai_cnt <= 24'h00_0000;
    end else if (rai_cnt != RAI_CYCLES) begin
      rai_cnt <= rai_cnt + 24'h00_0001;
    end
  end
  assign rai_status = (rai_cnt == RAI_CYCLES);
  // one-second time base for the continuous febe count
  assign sec_wrap = (sec_cnt == SEC_CYCLES - 24'h00_0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt <= 24'h00_0000;
    end else if (sec_wrap) begin
      sec_cnt <= 24'h00_0000;
    end else begin
      sec_cnt <= sec_cnt + 24'h00_0001;
    end
  end

  // e zeros only count in sync; the count saturates well above the threshold
  assign e_zero_event = line_in.e_strobe & line_in.crc_mf_sync & ~line_in.e_bit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_zero_cnt <= 11'h000;
      cfebe_hist <= '0;
    end else if (sec_wrap) begin
      cfebe_hist <= {cfebe_hist[`ENBOM_CFEBE_SECS-2:0], (e_zero_cnt >= `ENBOM_CFEBE_MIN)};
      e_zero_cnt <= {10'h000, e_zero_event};
    end else if (e_zero_event && e_zero_cnt != 11'h7ff) begin
      e_zero_cnt <= e_zero_cnt + 11'h001;
    end
  end

  assign cfebe_status = &cfebe_hist;
  // sa7 sliding window; ones at reset so no link id is claimed before data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa7_window <= 3'h7;
    end else if (nfas_take) begin
      sa7_window <= {sa7_window[1:0], line_in.sa[`ENBOM_CW_SA7]};
    end
  end

  // two or more zeros among the last three
  assign link_status = (~sa7_window[0] & ~sa7_window[1]) | (~sa7_window[0] & ~sa7_window[2]) |
                       (~sa7_window[1] & ~sa7_window[2]);

  // toggle detection on the three continuous statuses
  assign status_now = {rai_status, cfebe_status, link_status};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_prev <= 3'h0;
    end else begin
      status_prev <= status_now;
    end
  end

  // overhead flag sources
  always_comb begin
    oh_set = 6'h00;
    oh_set[`ENBOM_OH_NT_CRC] = cw_sample &&
      (next_cw[`ENBOM_CW_SA6] == `ENBOM_NT_CRC_A || next_cw[`ENBOM_CW_SA6] == `ENBOM_NT_CRC_B);
    oh_set[`ENBOM_OH_NT_FEBE] = cw_sample &&
      (next_cw[`ENBOM_CW_SA6] == `ENBOM_NT_FEBE_A || next_cw[`ENBOM_CW_SA6] == `ENBOM_NT_FEBE_B);
    oh_set[`ENBOM_OH_FEBE] = e_zero_event;
    oh_set[2:0] = status_now ^ status_prev;
  end

  // shared interrupt: any set flag whose enable is on; pattern bits carry no enable
  assign irq = (|(cw_flags & {cw_ctrl[`ENBOM_BIT_SIXTH_IRQ], cw_ctrl[4:0]})) |
               (|(oh_flags & oh_ctrl));

endmodule

// ===== logic/enbom_pkg.sv
// types shared by the overhead monitor and its codeword store
// assumes the framer delivers overhead bits as one-cycle strobes on pclk
package enbom_pkg;

  typedef logic [3:0] enbom_cw_type;

  // receive overhead from the framer, all sampled on pclk
  typedef struct packed {
    logic nfas_strobe;  // one pulse per nfas frame; a_bit and sa valid
    logic a_bit;
    logic [4:0] sa;     // sa4 .. sa8 in bits 4 .. 0
    logic smf_end;      // pulse after the last nfas frame of a crc sub-multiframe
    logic e_strobe;     // pulse per received e1 or e2 bit
    logic e_bit;
    logic crc_mf_sync;  // level: crc multiframe in sync
    logic basic_sync;   // level: basic frame in sync
  } enbom_line_type;

endpackage
